// ===== design/uhp_pkg.sv
// package for the per-pipe control logic of a usb host port
package uhp_pkg;
  // register offsets (byte addresses, word aligned only up to OFS_FLAG_SET)
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CTL_SET = 4'h4;
  localparam logic [3:0] OFS_CTL_CLR = 4'h8;
  localparam logic [3:0] OFS_FLAG_SET = 4'hC;
  localparam logic [3:0] OFS_FLAG_CLR = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_INREQ = 4'h9;
  // control bit positions
  localparam int B_IN_RX = 0;
  localparam int B_OUT_TX = 1;
  localparam int B_SETUP_TX = 2;
  localparam int B_FAULT = 3;
  localparam int B_NAK = 4;
  localparam int B_OVERRUN = 5;
  localparam int B_STALL = 6;
  localparam int B_SHORT = 7;
  localparam int B_BUSY = 12;
  localparam int B_HANDOFF = 14;
  localparam int B_DMA_BLK = 16;
  localparam int B_HALT = 17;
  localparam int B_TOGGLE = 18;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK = 32'h0007_50FF;
  localparam logic [15:0] FLAG_MASK = 16'h10FF;
  localparam logic [31:0] SET_MASK = 32'h0007_10FF;
  localparam logic [31:0] CLR_MASK = 32'h0003_50FF;

  typedef enum logic [1:0] {
    UHP_IN = 2'b00,
    UHP_OUT = 2'b01,
    UHP_SETUP = 2'b10
  } uhp_dir_e;

  // events coming from the pipe engine
  typedef struct packed {
    logic bank_done;
    logic stall_rx;
    logic in_done;
    logic toggle_done;
    logic [15:0] flag_evt;
  } uhp_evt_s;

  typedef struct packed {
    logic [31:0] control;
    logic [15:0] flags;
    logic [7:0] in_request_count;
    logic [8:0] in_done_cnt;
    logic configured_q;
    logic [31:0] rdata;
    logic rvalid;
    logic irq;
    logic bank_advance;
    logic toggle_pulse;
  } uhp_state_s;
endpackage

// ===== design/uhp_pipe_ctl.sv
// per-pipe control register block with avalon-mm slave
//
// Contract
// - writing one to short packet force sets short packet flag
// - writing one to busy bank force sets busy bank flag
// - flag force bits ignore zero writes and always read zero
// - in, out, setup irq enables set and cleared by strobes
// - underrun and pipe fault enables change only through strobes
// - nak and overrun enables set and cleared through strobes
// - stall and crc enables set and cleared through strobes
// - short packet enable set and cleared through strobes
// - busy bank enable at bit 12, set and cleared by strobes
// - out/setup: handoff set when bank frees, with tx flag
// - out/setup: handoff clear queues bank and switches bank
// - in: handoff set with received-in flag when packet stored
// - in: handoff clear releases bank and advances
// - halt set by strobe; halted pipe issues no requests
// - halt clear strobe drops halt, requests resume
// - halt set when unconfigured, stall received or fault flag
// - halt set after in_request_count plus one in requests
// - halt forced on pipe reset or enable
// - toggle reinit strobe raises bit 18, reinitialises toggle
// - hardware clears toggle reinit once done
`timescale 1ns/1ps
`default_nettype none
module uhp_pipe_ctl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic pipe_configured_i,
  input wire logic pipe_enable_i,
  input wire uhp_pkg::uhp_dir_e pipe_dir_i,
  input wire uhp_pkg::uhp_evt_s evt_i,
  output logic pipe_halt_o,
  output logic bank_advance_o,
  output logic toggle_reinit_o,
  output logic irq_o
);
  import uhp_pkg::*;

  uhp_state_s st_reg;
  uhp_state_s st_next;
  logic [31:0] wmask;
  logic wr_ctl_set;
  logic wr_ctl_clr;
  logic wr_flag_set;
  logic wr_flag_clr;
  logic wr_inreq;
  logic enable_q;

  ////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle per access, answer on the second edge
  always_comb begin
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  end

  assign wr_ctl_set = avs_write_i && st_reg.rvalid
    && avs_address_i == OFS_CTL_SET;
  assign wr_ctl_clr = avs_write_i && st_reg.rvalid
    && avs_address_i == OFS_CTL_CLR;
  assign wr_flag_set = avs_write_i && st_reg.rvalid
    && avs_address_i == OFS_FLAG_SET;
  assign wr_flag_clr = avs_write_i && st_reg.rvalid
    && avs_address_i == OFS_FLAG_CLR;
  assign wr_inreq = avs_write_i && st_reg.rvalid
    && avs_address_i == OFS_INREQ;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [15:0] fset_v;
    logic [15:0] fclr_v;
    logic halt_evt;
    set_v = '0;
    clr_v = '0;
    fset_v = '0;
    fclr_v = '0;
    halt_evt = 1'b0;
    st_next = st_reg;
    st_next.bank_advance = 1'b0;
    st_next.toggle_pulse = 1'b0;
    // a strobe register ignores zero bits
    if (wr_ctl_set) begin
      set_v = avs_writedata_i & wmask & SET_MASK;
    end
    if (wr_ctl_clr) begin
      clr_v = avs_writedata_i & wmask & CLR_MASK;
    end
    if (wr_flag_set) begin
      fset_v = avs_writedata_i[15:0] & wmask[15:0] & FLAG_MASK;
    end
    if (wr_flag_clr) begin
      fclr_v = avs_writedata_i[15:0] & wmask[15:0] & FLAG_MASK;
    end
    if (wr_inreq) begin
      st_next.in_request_count = avs_writedata_i[7:0];
    end
    // hardware events beat a software flag clear
    st_next.flags = (st_reg.flags & ~fclr_v) | fset_v | evt_i.flag_evt;
    // bank handoff set on completion event
    if (evt_i.bank_done && pipe_dir_i != UHP_IN) begin
      set_v[B_HANDOFF] = 1'b1;
      st_next.flags[pipe_dir_i == UHP_OUT ? B_OUT_TX : B_SETUP_TX]
        = 1'b1;
    end
    if (evt_i.bank_done && pipe_dir_i == UHP_IN) begin
      set_v[B_HANDOFF] = 1'b1;
      st_next.flags[B_IN_RX] = 1'b1;
    end
    // software clear of a set handoff hands the bank on
    if (clr_v[B_HANDOFF] && st_reg.control[B_HANDOFF]) begin
      st_next.bank_advance = 1'b1;
    end
    // in request counting
    if (evt_i.in_done && pipe_dir_i == UHP_IN) begin
      st_next.in_done_cnt = 9'(st_reg.in_done_cnt + 9'h001);
      if (9'(st_reg.in_done_cnt + 9'h001)
          >= 9'({1'b0, st_reg.in_request_count} + 9'h001)) begin
        halt_evt = 1'b1;
        st_next.in_done_cnt = 9'h000;
      end
    end
    if (!pipe_configured_i || evt_i.stall_rx
        || st_reg.flags[B_FAULT]) begin
      halt_evt = 1'b1;
    end
    st_next.configured_q = pipe_configured_i;
    if ((pipe_configured_i && !st_reg.configured_q)
        || (pipe_enable_i && !enable_q)) begin
      halt_evt = 1'b1;
      st_next.in_done_cnt = 9'h000;
    end
    if (set_v[B_TOGGLE] && !st_reg.control[B_TOGGLE]) begin
      st_next.toggle_pulse = 1'b1;
    end
    // clear has priority over set
    st_next.control = ((st_reg.control | set_v) & ~clr_v)
      & CONTROL_MASK;
    if (halt_evt) begin
      st_next.control[B_HALT] = 1'b1;
    end
    if (evt_i.toggle_done) begin
      st_next.control[B_TOGGLE] = 1'b0;
    end
    st_next.irq = |(st_next.flags
      & st_next.control[15:0] & FLAG_MASK);
    // read path
    st_next.rvalid = (avs_read_i || avs_write_i) && !st_reg.rvalid;
    st_next.rdata = 32'h0000_0000;
    if (avs_read_i && !st_reg.rvalid) begin
      unique case (avs_address_i)
        OFS_CONTROL: st_next.rdata = st_reg.control;
        OFS_STATUS: st_next.rdata = {16'h0000, st_reg.flags};
        OFS_INREQ: st_next.rdata = {24'h000000, st_reg.in_request_count};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      enable_q <= 1'b0;
    end else begin
      st_reg <= st_next;
      enable_q <= pipe_enable_i;
    end
  end

  assign avs_readdata_o = st_reg.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_reg.rvalid;
  assign pipe_halt_o = st_reg.control[B_HALT];
  assign bank_advance_o = st_reg.bank_advance;
  assign toggle_reinit_o = st_reg.toggle_pulse;
  assign irq_o = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////
  a_clr_wins_set: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl_clr && avs_writedata_i[B_HANDOFF] && avs_byteenable_i[1]
    |=> !st_reg.control[B_HANDOFF])
    else $error("clear lost to set");
  a_halt_on_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.stall_rx |=> pipe_halt_o) else $error("halt missed stall");
  a_halt_on_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.flags[B_FAULT] |=> pipe_halt_o)
    else $error("halt missed fault");
  a_halt_clr_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl_clr && avs_writedata_i[B_HALT] && avs_byteenable_i[2]
    && pipe_configured_i && st_reg.configured_q && !evt_i.stall_rx
    && !st_reg.flags[B_FAULT] && !evt_i.in_done
    && !(pipe_enable_i && !enable_q) |=> !pipe_halt_o)
    else $error("halt clear ignored");
  a_handoff_in: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.bank_done && pipe_dir_i == UHP_IN && !wr_ctl_clr
    |=> st_reg.control[B_HANDOFF] && st_reg.flags[B_IN_RX])
    else $error("in handoff not set");
  a_handoff_out: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.bank_done && pipe_dir_i == UHP_OUT && !wr_ctl_clr
    |=> st_reg.control[B_HANDOFF] && st_reg.flags[B_OUT_TX])
    else $error("out handoff not set");
  a_bank_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl_clr && avs_writedata_i[B_HANDOFF] && avs_byteenable_i[1]
    && st_reg.control[B_HANDOFF] |=> bank_advance_o ##1 !bank_advance_o)
    else $error("bank not advanced");
  a_toggle_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.toggle_done |=> !st_reg.control[B_TOGGLE])
    else $error("toggle bit stuck");
  a_short_force: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_flag_set && avs_writedata_i[B_SHORT] && avs_byteenable_i[0]
    |=> st_reg.flags[B_SHORT]) else $error("short force lost");
  a_busy_force: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_flag_set && avs_writedata_i[B_BUSY] && avs_byteenable_i[1]
    |=> st_reg.flags[B_BUSY]) else $error("busy force lost");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> |(st_reg.flags & st_reg.control[15:0]))
    else $error("irq without cause");
endmodule // uhp_pipe_ctl
`default_nettype wire

// ===== bench/uhp_engine_model.sv
// pipe engine stand-in that raises event pulses
`timescale 1ns/1ps
`default_nettype none
module uhp_engine_model (
  input wire logic clk_i,
  output var uhp_pkg::uhp_evt_s evt_o
);
  import uhp_pkg::*;
  initial evt_o = '0;
  // one-cycle pulse, launched and dropped right after edges
  task automatic fire(input uhp_evt_s e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask
endmodule // uhp_engine_model
`default_nettype wire

// ===== bench/uhp_pipe_ctl_tb_top.sv
// register-level bench for the pipe control block
`timescale 1ns/1ps
`default_nettype none
module uhp_pipe_ctl_tb_top;
  import uhp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic wt, halt, adv, tog, irq, cfg = 1'b1, en = 1'b0;
  uhp_dir_e dir = UHP_OUT;
  uhp_evt_s evt;
  int failures = 0, cmp_count = 0, nadv = 0, ntog = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    nadv += (adv === 1'b1);
    ntog += (tog === 1'b1);
  end
  uhp_engine_model u_eng (.clk_i(clk_i), .evt_o(evt));
  uhp_pipe_ctl u_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .pipe_configured_i(cfg),
    .pipe_enable_i(en), .pipe_dir_i(dir), .evt_i(evt),
    .pipe_halt_o(halt), .bank_advance_o(adv), .toggle_reinit_o(tog),
    .irq_o(irq));
  task automatic results();
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr_i <= w;
    rd_i <= !w;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdat;
    if (n >= 20) begin
      failures++;
      results();
    end
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic unhalt();
    wr(OFS_CTL_CLR, 32'h0002_0000);
    settle();
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    unhalt();
    rdc(OFS_CONTROL, 32'h0);
    for (int b = 0; b < 13; b++) begin
      if (FLAG_MASK[b]) begin
        wr(OFS_CTL_SET, 32'h1 << b);
        rdc(OFS_CONTROL, 32'h1 << b);
        wr(OFS_CTL_SET, 32'h0);
        wr(OFS_CTL_CLR, 32'h0);
        rdc(OFS_CONTROL, 32'h1 << b);
        wr(OFS_CTL_CLR, 32'h1 << b);
        rdc(OFS_CONTROL, 32'h0);
      end
    end
    wr(OFS_FLAG_SET, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    wr(OFS_FLAG_SET, 32'h0000_1080);
    rdc(OFS_STATUS, 32'h0000_1080);
    rdc(OFS_FLAG_SET, 32'h0);
    rdc(OFS_CTL_SET, 32'h0);
    wr(OFS_CTL_SET, 32'h1 << B_SHORT);
    settle();
    chk(irq, 1'b1);
    wr(OFS_CTL_CLR, 32'h1 << B_SHORT);
    settle();
    chk(irq, 1'b0);
    wr(OFS_FLAG_CLR, 32'h10FF);
    wr(OFS_CTL_SET, 32'h1 << B_HALT);
    settle();
    chk(halt, 1'b1);
    unhalt();
    chk(halt, 1'b0);
    u_eng.fire('{stall_rx: 1'b1, default: '0});
    settle();
    chk(halt, 1'b1);
    unhalt();
    cfg <= 1'b0;
    settle();
    chk(halt, 1'b1);
    cfg <= 1'b1;
    en <= 1'b1;
    unhalt();
    en <= 1'b0;
    settle();
    en <= 1'b1;
    settle();
    chk(halt, 1'b1);
    unhalt();
    u_eng.fire('{flag_evt: 16'h0008, default: '0});
    settle();
    chk(halt, 1'b1);
    wr(OFS_FLAG_CLR, 32'h10FF);
    unhalt();
    u_eng.fire('{bank_done: 1'b1, flag_evt: 16'h0002, default: '0});
    rdc(OFS_CONTROL, 32'h1 << B_HANDOFF);
    wr(OFS_CTL_CLR, 32'h1 << B_HANDOFF);
    settle();
    chk(nadv, 1);
    dir <= UHP_IN;
    wr(OFS_INREQ, 32'h1);
    u_eng.fire('{bank_done: 1'b1, in_done: 1'b1, flag_evt: 16'h0001,
      default: '0});
    rdc(OFS_CONTROL, 32'h1 << B_HANDOFF);
    wr(OFS_CTL_CLR, 32'h1 << B_HANDOFF);
    settle();
    chk(nadv, 2);
    u_eng.fire('{in_done: 1'b1, default: '0});
    settle();
    chk(halt, 1'b1);
    wr(OFS_CTL_SET, 32'h1 << B_TOGGLE);
    settle();
    chk(ntog, 1);
    u_eng.fire('{toggle_done: 1'b1, default: '0});
    rdc(OFS_CONTROL, 32'h1 << B_HALT);
    results();
  end
endmodule // uhp_pipe_ctl_tb_top
`default_nettype wire
